// File: pkg/aux_flags_pkg.sv
// Package with register map, field positions and timing for the status unit.
package aux_flags_pkg;

	// ----------------------------------------------------------------
	// Register byte addresses
	// ----------------------------------------------------------------
	localparam logic [7:0] CYC_NOW_LO_ADDR = 8'h00;
	localparam logic [7:0] CYC_NOW_HI_ADDR = 8'h04;
	localparam logic [7:0] CYC_MAX_LO_ADDR = 8'h08;
	localparam logic [7:0] CYC_MAX_HI_ADDR = 8'h0c;
	localparam logic [7:0] EXEC_FLAGS_ADDR = 8'h10;
	localparam logic [7:0] PULSE_ADDR = 8'h14;
	localparam logic [7:0] NET_STATUS_ADDR = 8'h18;
	localparam logic [7:0] COMPL_BASE_ADDR = 8'h20;
	localparam logic [7:0] BANK_ADDR = 8'h40;
	localparam logic [7:0] CTRL_ADDR = 8'h44;

	// ----------------------------------------------------------------
	// Field positions of exec_result_flags
	// ----------------------------------------------------------------
	localparam int ERR_BIT = 3;
	localparam int CARRY_BIT = 4;
	localparam int GREATER_BIT = 5;
	localparam int EQUAL_BIT = 6;
	localparam int LESS_BIT = 7;
	localparam int NEG_BIT = 8;
	localparam int OVF_BIT = 9;
	localparam int UNF_BIT = 10;
	localparam int STEP_BIT = 12;
	localparam int FIRST_BIT = 15;
	localparam int BANK_INST_BIT = 15;
	localparam int NPORTS = 8;

	// ----------------------------------------------------------------
	// Control register bits (run level and mode)
	// ----------------------------------------------------------------
	localparam int CTRL_RUN_BIT = 0;
	localparam int CTRL_SFC_BIT = 1;
	localparam logic [15:0] FLAGS_RST = 16'h0000;

	// ----------------------------------------------------------------
	// Timing
	// ----------------------------------------------------------------
	localparam int CLK_HZ = 25000000;
	localparam int TENTH_MS_US = 100;
	localparam int TENTH_MS_CYC = CLK_HZ / 1000000 * TENTH_MS_US;
	localparam int PULSE_MS_0 = 100;
	localparam int PULSE_MS_1 = 200;
	localparam int PULSE_MS_2 = 1000;
	localparam int PULSE_MS_3 = 20;
	localparam int TICKS_1MS = CLK_HZ / 1000;

	// ----------------------------------------------------------------
	// Operation reports from the instruction engine and network completions
	// ----------------------------------------------------------------
	typedef enum logic [2:0] {
		OP_NONE = 3'b000,
		OP_ARITH = 3'b001,
		OP_CMP = 3'b010,
		OP_SHIFT = 3'b011,
		OP_SET_CY = 3'b100,
		OP_CLR_CY = 3'b101
	} op_kind_t;

	typedef struct packed {
		logic valid;
		op_kind_t kind;
		logic bad_operand;
		logic carry;
		logic zero;
		logic msb;
		logic overflow;
		logic underflow;
		logic a_gt_b;
		logic a_lt_b;
	} op_report_t;

	typedef struct packed {
		logic done;
		logic [2:0] port;
		logic error;
		logic [15:0] code;
	} net_done_t;

endpackage

// File: verilog/pulse_gen.sv
// Free-running 50 percent duty pulse bit from a millisecond tick.
`timescale 1ns/100ps
module pulse_gen #(
	parameter int PERIOD_MS = 100
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rstn,
	// Time base
	input wire logic ms_tick,
	// Pulse out
	output logic pulse
);
	import aux_flags_pkg::*;

	localparam int HALF = PERIOD_MS / 2;
	localparam int W = $clog2(PERIOD_MS + 1);

	logic [W-1:0] cnt_q;

	// High for the first half of the period, low for the second.
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			cnt_q <= '0;
		end else if (ms_tick) begin
			if (cnt_q == W'(PERIOD_MS - 1)) begin
				cnt_q <= '0;
			end else begin
				cnt_q <= cnt_q + W'(1);
			end
		end
	end

	assign pulse = (cnt_q < W'(HALF));
endmodule

// File: verilog/aux_status_flags_unit.sv
// Auxiliary status flag unit with Avalon-MM register access.
//
// The implementer's own choices: register access over Avalon-MM and the register offsets.
`timescale 1ns/100ps
module aux_status_flags_unit (
	// Clock and reset
	input wire logic clk,
	input wire logic rstn,
	// Avalon-MM slave
	input wire logic [7:0] address,
	input wire logic read,
	input wire logic write,
	input wire logic [31:0] writedata,
	input wire logic [3:0] byteenable,
	output logic [31:0] readdata,
	output logic waitrequest,
	// Scan and instruction engine
	input wire logic scan_start,
	input wire logic program_end,
	input wire logic step_start,
	input wire logic action_start,
	input wire logic sched_int_start,
	input wire aux_flags_pkg::op_report_t op_report,
	output logic suppress_exec,
	output logic carry_in,
	// Network ports and expansion memory
	input wire logic [aux_flags_pkg::NPORTS-1:0] port_enable,
	input wire aux_flags_pkg::net_done_t net_done,
	input wire logic [3:0] bank_number,
	input wire logic bank_mounted,
	// Flag word to the program
	output logic [15:0] flags_word
);
	import aux_flags_pkg::*;

	// ----------------------------------------------------------------
	// BCD increment of an eight digit value
	// ----------------------------------------------------------------
	function automatic logic [31:0] bcd_inc(input logic [31:0] v);
		logic [31:0] r;
		logic c;
		r = v;
		c = 1'b1;
		for (int i = 0; i < 8; i++) begin
			if (c) begin
				c = (r[i*4 +: 4] == 4'h9);
				r[i*4 +: 4] = c ? 4'h0 : r[i*4 +: 4] + 4'h1;
			end
		end
		return r;
	endfunction

	// ----------------------------------------------------------------
	// Cycle time measurement
	// ----------------------------------------------------------------
	localparam int TW = $clog2(TENTH_MS_CYC);
	logic [TW-1:0] tenth_cnt_q;
	logic [31:0] run_time_q;
	logic [31:0] cyc_now_q;
	logic [31:0] cyc_max_q;
	logic tenth_tick;

	assign tenth_tick = (tenth_cnt_q == TW'(TENTH_MS_CYC - 1));

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			tenth_cnt_q <= '0;
		end else if (scan_start || tenth_tick) begin
			tenth_cnt_q <= '0;
		end else begin
			tenth_cnt_q <= tenth_cnt_q + TW'(1);
		end
	end

	// Saturates at all nines rather than wrapping to zero.
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			run_time_q <= 32'h0000_0000;
		end else if (scan_start) begin
			run_time_q <= 32'h0000_0000;
		end else if (tenth_tick && run_time_q != 32'h9999_9999) begin
			run_time_q <= bcd_inc(run_time_q);
		end
	end

	// BCD digits compare correctly as plain binary numbers.
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			cyc_now_q <= 32'h0000_0000;
			cyc_max_q <= 32'h0000_0000;
		end else if (scan_start) begin
			cyc_now_q <= run_time_q;
			if (run_time_q > cyc_max_q) begin
				cyc_max_q <= run_time_q;
			end
		end
	end

	// ----------------------------------------------------------------
	// Control register: run and chart mode
	// ----------------------------------------------------------------
	logic [1:0] ctrl_q;
	logic run_q;
	logic sel_ctrl_wr;

	assign sel_ctrl_wr = write && !waitrequest && address == CTRL_ADDR;

	// The run bit is also kept one cycle late to see it switch on.
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			ctrl_q <= 2'h0;
			run_q <= 1'b0;
		end else begin
			run_q <= ctrl_q[CTRL_RUN_BIT];
			if (sel_ctrl_wr && byteenable[0]) begin
				ctrl_q <= writedata[1:0];
			end
		end
	end

	// ----------------------------------------------------------------
	// Result flags
	// ----------------------------------------------------------------
	logic err_q, cy_q, gr_q, eq_q, le_q, neg_q, of_q, uf_q;
	logic op_ok;
	logic sel_flags_wr;

	assign op_ok = op_report.valid && !suppress_exec;
	assign suppress_exec = err_q || (op_report.valid &&
		op_report.bad_operand);
	assign carry_in = cy_q;
	assign sel_flags_wr = write && !waitrequest &&
		address == EXEC_FLAGS_ADDR && byteenable[0];

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			err_q <= 1'b0;
		end else if (op_report.valid && op_report.bad_operand) begin
			err_q <= 1'b1;
		end else if (scan_start) begin
			err_q <= 1'b0;
		end else if (sel_flags_wr && !writedata[ERR_BIT]) begin
			err_q <= 1'b0;
		end
	end

	// A set, clear, arithmetic or shift report wins over the end-of-program clear.
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			cy_q <= 1'b0;
		end else if (op_ok && op_report.kind == OP_SET_CY) begin
			cy_q <= 1'b1;
		end else if (op_ok && op_report.kind == OP_CLR_CY) begin
			cy_q <= 1'b0;
		end else if (op_ok && op_report.kind inside {OP_ARITH, OP_SHIFT}) begin
			cy_q <= op_report.carry;
		end else if (program_end) begin
			cy_q <= 1'b0;
		end
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			{gr_q, eq_q, le_q} <= 3'h0;
			{neg_q, of_q, uf_q} <= 3'h0;
		end else if (op_ok && op_report.kind == OP_CMP) begin
			gr_q <= op_report.a_gt_b;
			eq_q <= !op_report.a_gt_b && !op_report.a_lt_b;
			le_q <= op_report.a_lt_b;
		end else if (op_ok && op_report.kind == OP_ARITH) begin
			eq_q <= op_report.zero;
			neg_q <= op_report.msb;
			of_q <= op_report.overflow;
			uf_q <= op_report.underflow;
		end else if (program_end) begin
			{gr_q, eq_q, le_q} <= 3'h0;
			{neg_q, of_q, uf_q} <= 3'h0;
		end
	end

	// ----------------------------------------------------------------
	// Step and first-cycle flags
	// ----------------------------------------------------------------
	logic step_pend_q, step_q, first_pend_q, first_q;

	// A request is latched and shown for the whole next scan. A request
	// that meets a scan start is used up there, so it shows only once.
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			step_pend_q <= 1'b0;
			step_q <= 1'b0;
		end else if (scan_start) begin
			step_pend_q <= 1'b0;
			step_q <= step_pend_q || step_start;
		end else if (step_start) begin
			step_pend_q <= 1'b1;
		end
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			first_pend_q <= 1'b0;
		end else if (!ctrl_q[CTRL_SFC_BIT] && ctrl_q[CTRL_RUN_BIT] &&
			!run_q) begin
			first_pend_q <= 1'b1;
		end else if (ctrl_q[CTRL_SFC_BIT] && action_start) begin
			first_pend_q <= 1'b1;
		end else if (scan_start) begin
			first_pend_q <= 1'b0;
		end
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			first_q <= 1'b0;
		end else if (sched_int_start) begin
			first_q <= 1'b1;
		end else if (scan_start) begin
			first_q <= first_pend_q;
		end
	end

	// ----------------------------------------------------------------
	// Pulse bits on a free-running millisecond base
	// ----------------------------------------------------------------
	localparam int MW = $clog2(TICKS_1MS);
	localparam int PERIODS [4] = '{PULSE_MS_0, PULSE_MS_1, PULSE_MS_2,
		PULSE_MS_3};
	logic [MW-1:0] ms_cnt_q;
	logic ms_tick;
	logic [3:0] pulse_raw;
	logic [3:0] pulse_q;

	// Independent of the scan so the periods never stretch.
	assign ms_tick = (ms_cnt_q == MW'(TICKS_1MS - 1));

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			ms_cnt_q <= '0;
		end else if (ms_tick) begin
			ms_cnt_q <= '0;
		end else begin
			ms_cnt_q <= ms_cnt_q + MW'(1);
		end
	end

	for (genvar g = 0; g < 4; g++) begin : g_pulse
		pulse_gen #(
			.PERIOD_MS(PERIODS[g])
		) u_pulse (
			.clk(clk),
			.rstn(rstn),
			.ms_tick(ms_tick),
			.pulse(pulse_raw[g])
		);
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			pulse_q <= 4'h0;
		end else begin
			pulse_q <= pulse_raw;
		end
	end

	// ----------------------------------------------------------------
	// Network status and completion codes
	// ----------------------------------------------------------------
	logic [NPORTS-1:0] port_en_q;
	logic [NPORTS-1:0] port_err_q;
	logic [15:0] compl_q [NPORTS];

	// Error bit reflects the outcome of the latest operation per port.
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			port_en_q <= '0;
			port_err_q <= '0;
			for (int i = 0; i < NPORTS; i++) begin
				compl_q[i] <= 16'h0000;
			end
		end else begin
			port_en_q <= port_enable;
			if (net_done.done) begin
				port_err_q[net_done.port] <= net_done.error;
				compl_q[net_done.port] <= net_done.code;
			end
		end
	end

	// ----------------------------------------------------------------
	// Register read and flag word
	// ----------------------------------------------------------------
	logic [15:0] bank_word;
	logic [15:0] rd_mux;
	logic [2:0] port_idx;
	logic rd_ack_q;

	assign bank_word = {bank_mounted, 11'h000, bank_number};
	assign flags_word = {first_q, 2'h0, step_q, 1'b0, uf_q, of_q, neg_q,
		le_q, eq_q, gr_q, cy_q, err_q, 3'h0};
	assign port_idx = address[4:2];
	// A read waits one cycle so that the registered data stand when
	// waitrequest drops; writes are taken at once.
	assign waitrequest = read && !rd_ack_q;

	always_comb begin
		rd_mux = 16'h0000;
		if (address >= COMPL_BASE_ADDR &&
			address < COMPL_BASE_ADDR + 8'(NPORTS * 4)) begin
			rd_mux = compl_q[port_idx];
		end else begin
			case (address)
			CYC_NOW_LO_ADDR: rd_mux = cyc_now_q[15:0];
			CYC_NOW_HI_ADDR: rd_mux = cyc_now_q[31:16];
			CYC_MAX_LO_ADDR: rd_mux = cyc_max_q[15:0];
			CYC_MAX_HI_ADDR: rd_mux = cyc_max_q[31:16];
			EXEC_FLAGS_ADDR: rd_mux = flags_word;
			PULSE_ADDR: rd_mux = {12'h000, pulse_q};
			NET_STATUS_ADDR: rd_mux = {port_err_q, port_en_q};
			BANK_ADDR: rd_mux = bank_word;
			CTRL_ADDR: rd_mux = {14'h0000, ctrl_q};
			default: rd_mux = 16'h0000;
			endcase
		end
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			readdata <= 32'h0000_0000;
			rd_ack_q <= 1'b0;
		end else begin
			rd_ack_q <= read && !rd_ack_q;
			if (read) begin
				readdata <= {16'h0000, rd_mux};
			end
		end
	end
endmodule

// File: test/aux_status_flags_unit_assertions.sv
// Checker for the port behaviour of the status flag unit.
`timescale 1ns/100ps
module aux_status_flags_unit_chk
	import aux_flags_pkg::*;
(
	// Clock and reset
	input wire logic clk,
	input wire logic rstn,
	// Register bus
	input wire logic [7:0] address,
	input wire logic read,
	input wire logic [31:0] readdata,
	input wire logic waitrequest,
	// Engine and status inputs
	input wire logic program_end,
	input wire aux_flags_pkg::op_report_t op_report,
	input wire logic [3:0] bank_number,
	input wire logic bank_mounted,
	// Outputs to the program
	input wire logic suppress_exec,
	input wire logic carry_in,
	input wire logic [15:0] flags_word
);
	default clocking @(posedge clk); endclocking
	default disable iff (!rstn);
	logic ok;
	// A suppressed instruction must leave the result flags alone.
	assign ok = op_report.valid && !suppress_exec;

	idle_no_wait_a: assert property (!read |-> !waitrequest)
		else $error("waitrequest without a read");
	rd_answer_a: assert property (read && waitrequest |=> !waitrequest)
		else $error("read not answered in two cycles");
	err_set_a: assert property (
		op_report.valid && op_report.bad_operand |=> flags_word[ERR_BIT])
		else $error("error flag not set");
	suppress_a: assert property (
		flags_word[ERR_BIT] |-> suppress_exec)
		else $error("execution not suppressed");
	suppress_hold_a: assert property (
		op_report.valid && suppress_exec && !program_end |=>
		flags_word[10:4] == $past(flags_word[10:4]))
		else $error("suppressed instruction changed flags");
	carry_set_a: assert property (
		ok && op_report.kind == OP_SET_CY |=> carry_in && flags_word[CARRY_BIT])
		else $error("carry not set");
	greater_set_a: assert property (
		ok && op_report.kind == OP_CMP && op_report.a_gt_b |=>
		flags_word[GREATER_BIT])
		else $error("greater flag missing");
	less_set_a: assert property (
		ok && op_report.kind == OP_CMP && op_report.a_lt_b |=>
		flags_word[LESS_BIT])
		else $error("less flag missing");
	neg_set_a: assert property (
		ok && op_report.kind == OP_ARITH && op_report.msb |=>
		flags_word[NEG_BIT])
		else $error("negative flag missing");
	end_clear_a: assert property (
		program_end && !op_report.valid |=> flags_word[10:4] == 7'h00)
		else $error("result flags not cleared");
	unmapped_a: assert property (read && address == 8'h80 |=> readdata == 32'h0)
		else $error("unmapped read not zero");
	bank_word_a: assert property (
		read && address == BANK_ADDR |=>
		readdata[15] == $past(bank_mounted) &&
		readdata[3:0] == $past(bank_number))
		else $error("bank word wrong");
endmodule

// File: test/aux_status_flags_unit_tb.sv
// Self-checking testbench for the status flag unit.
`timescale 1ns/100ps
module aux_status_flags_unit_tb;
	import aux_flags_pkg::*;
	logic clk = 0, rstn = 0, read = 0, write = 0;
	logic [7:0] address = 8'h00;
	logic [31:0] writedata = 32'h0, readdata;
	logic [3:0] byteenable = 4'h0, bank_number = 4'h0;
	logic waitrequest, suppress_exec, carry_in, bank_mounted = 0;
	logic scan_start = 0, program_end = 0, step_start = 0;
	logic action_start = 0, sched_int_start = 0;
	logic [7:0] port_enable = 8'h00;
	logic [15:0] flags_word;
	op_report_t op_report = '0;
	net_done_t net_done = '0;
	int miscompares = 0, samples_checked = 0;
	logic sup;
	logic [31:0] d;

	aux_status_flags_unit DUT (.clk(clk), .rstn(rstn), .address(address),
		.read(read), .write(write), .writedata(writedata),
		.byteenable(byteenable), .readdata(readdata),
		.waitrequest(waitrequest), .scan_start(scan_start),
		.program_end(program_end), .step_start(step_start),
		.action_start(action_start), .sched_int_start(sched_int_start),
		.op_report(op_report), .suppress_exec(suppress_exec),
		.carry_in(carry_in), .port_enable(port_enable),
		.net_done(net_done), .bank_number(bank_number),
		.bank_mounted(bank_mounted), .flags_word(flags_word));

	initial forever #20 clk = ~clk;

	// -----------------------------------------------------------------
	// Shared tasks
	// -----------------------------------------------------------------
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp) begin
			miscompares++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// Request is held until waitrequest is seen low at a rising edge;
	// read data are taken at that same edge.
	task automatic bus(input logic rd, input logic [7:0] a,
		input logic [31:0] wd);
		@(posedge clk);
		address <= a;
		writedata <= wd;
		byteenable <= 4'hf;
		read <= rd;
		write <= !rd;
		@(posedge clk);
		while (waitrequest !== 1'b0) @(posedge clk);
		d = readdata;
		read <= 0;
		write <= 0;
	endtask

	task automatic op(input op_kind_t k, input logic [7:0] f);
		@(posedge clk);
		op_report <= {1'b1, k, f};
		@(negedge clk);
		sup = suppress_exec;
		@(posedge clk);
		op_report <= '0;
		@(negedge clk);
	endtask

	task automatic scan();
		@(posedge clk);
		scan_start <= 1;
		@(posedge clk);
		scan_start <= 0;
		@(negedge clk);
	endtask

	task automatic pend();
		@(posedge clk);
		program_end <= 1;
		@(posedge clk);
		program_end <= 0;
		@(negedge clk);
	endtask

	// -----------------------------------------------------------------
	// Scenarios
	// -----------------------------------------------------------------
	task automatic t_cycle();
		scan();
		repeat (31250) @(posedge clk);
		scan();
		bus(1, CYC_NOW_LO_ADDR, 0); chk(d[15:0], 16'h0012);
		bus(1, CYC_NOW_HI_ADDR, 0); chk(d[15:0], 16'h0000);
		repeat (6250) @(posedge clk);
		scan();
		bus(1, CYC_NOW_LO_ADDR, 0); chk(d[15:0], 16'h0002);
		bus(1, CYC_MAX_LO_ADDR, 0); chk(d[15:0], 16'h0012);
	endtask

	task automatic t_flags();
		op(OP_CMP, 8'h02); chk(flags_word[GREATER_BIT], 1);
		op(OP_CMP, 8'h20); chk(flags_word[EQUAL_BIT], 1);
		op(OP_CMP, 8'h01); chk(flags_word[LESS_BIT], 1);
		pend(); chk(flags_word[10:4], 0);
		op(OP_ARITH, 8'h7c); chk(flags_word[10:4], 7'h75);
		chk(carry_in, 1);
		op(OP_CLR_CY, 8'h00); chk(carry_in, 0);
		op(OP_SHIFT, 8'h40); chk(flags_word[CARRY_BIT], 1);
		op(OP_CLR_CY, 8'h00);
		op(OP_SET_CY, 8'h00); chk(carry_in, 1);
		pend();
	endtask

	task automatic t_error();
		op(OP_ARITH, 8'hff); chk(sup, 1);
		chk({flags_word[ERR_BIT], flags_word[10:4]}, 8'h80);
		op(OP_ARITH, 8'h7c); chk(sup, 1);
		chk(flags_word[10:4], 0);
		bus(0, EXEC_FLAGS_ADDR, 0);
		@(negedge clk);
		chk({flags_word[ERR_BIT], suppress_exec}, 0);
	endtask

	task automatic t_step_first();
		@(posedge clk) step_start <= 1;
		@(posedge clk) step_start <= 0;
		scan(); chk(flags_word[STEP_BIT], 1);
		scan(); chk(flags_word[STEP_BIT], 0);
		bus(0, CTRL_ADDR, 32'h1);
		scan(); chk(flags_word[FIRST_BIT], 1);
		scan(); chk(flags_word[FIRST_BIT], 0);
		@(posedge clk) sched_int_start <= 1;
		@(posedge clk) sched_int_start <= 0;
		@(negedge clk); chk(flags_word[FIRST_BIT], 1);
		scan();
		scan();
		bus(0, CTRL_ADDR, 32'h3);
		@(posedge clk) action_start <= 1;
		@(posedge clk) action_start <= 0;
		scan(); chk(flags_word[FIRST_BIT], 1);
	endtask

	task automatic t_net_bank();
		@(posedge clk) port_enable <= 8'ha5;
		@(posedge clk) net_done <= {1'b1, 3'd7, 1'b1, 16'h1234};
		@(posedge clk) net_done <= {1'b1, 3'd0, 1'b0, 16'h0042};
		@(posedge clk) net_done <= '0;
		bus(0, NET_STATUS_ADDR, 32'hffff);
		bus(1, NET_STATUS_ADDR, 0); chk(d[15:0], 16'h80a5);
		bus(1, 8'h3c, 0); chk(d[15:0], 16'h1234);
		bus(1, COMPL_BASE_ADDR, 0); chk(d[15:0], 16'h0042);
		bus(1, 8'h80, 0); chk(d, 0);
		bus(1, PULSE_ADDR, 0); chk(d[15:4], 0);
		chk(d[3:0], 4'hf);
		bank_number <= 4'h6;
		bank_mounted <= 1;
		bus(1, BANK_ADDR, 0); chk(d[15:0], 16'h8006);
		bank_mounted <= 0;
		bus(1, BANK_ADDR, 0); chk(d[15:0], 16'h0006);
	endtask

	task automatic print_verdict();
		$display("checks=%0d mismatches=%0d", samples_checked, miscompares);
		if (miscompares == 0 && samples_checked > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	initial begin
		repeat (16) @(posedge clk);
		rstn <= 1;
		@(negedge clk);
		chk(flags_word, FLAGS_RST);
		t_cycle();
		t_flags();
		t_error();
		t_step_first();
		t_net_bank();
		print_verdict();
	end

	// The tests need about 40000 cycles; twice that means a hang.
	initial begin
		repeat (80000) @(posedge clk);
		miscompares++;
		print_verdict();
	end
endmodule

bind aux_status_flags_unit aux_status_flags_unit_chk u_chk (.clk(clk),
	.rstn(rstn), .address(address), .read(read), .readdata(readdata),
	.waitrequest(waitrequest), .program_end(program_end),
	.op_report(op_report), .bank_number(bank_number),
	.bank_mounted(bank_mounted), .suppress_exec(suppress_exec),
	.carry_in(carry_in), .flags_word(flags_word));
